// >>> logic/temp_sensor_controller.sv
// Temperature sensor controller: APB registers, sensor pin drive,
// reading capture, min/max tracking and the alarm flag.
// Assumes the APB master and the sensor macro share clk; readings on
// sensor_data are stable when a conversion completes.
//
// Contract
// - Readings are unsigned 7-bit Celsius values.
// - Load new reading every twelve sensor clocks.
// - New reading sets flag; read clears it.
// - Track lowest and highest readings.
// - Armed: reading at or above limit alarms.
// - Interrupt on each alarm rise; software clears.
// - Control 0x00, status 0x04, limit 0x08.
// - Sensor clock is system clock over 2*ratio.
// - Control bit 7 drives power-down low-active.
// - Control bit 1 drives sensor reset.
// - Control bit 0 gates sensor clock.
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module temp_sensor_controller
  import temp_sensor_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  input  wire temp_t       sensor_data,        // Sensor result bus.
  output logic             sensor_clk,         // Sensor clock out.
  output logic             sensor_reset_input, // Sensor reset, low active.
  output logic             sensor_power_on,    // Power-down, low active.
  output logic [4:0]       offset_trim,        // Offset trim to sensor.
  output logic             alarm_irq           // Alarm rise pulse.
);
  // Whole registered state of the controller.
  typedef struct packed {
    logic [31:0] ctrl;      // Control register image.
    temp_t       data;      // Latest reading.
    temp_t       min;       // Lowest reading seen.
    temp_t       max;       // Highest reading seen.
    logic        new_samp;  // New sample flag.
    logic        alarm;     // Alarm flag.
    temp_t       limit;     // Alarm limit.
    logic [3:0]  edges;     // Sensor clock rises since last load.
    cap_state_t  cap;       // Capture sequencer state.
    logic [31:0] rdata;     // Read data, held for one access.
    logic        ready;     // APB ready.
    logic        irq;       // Interrupt pulse.
    logic        sclk;      // Sensor clock, retimed to an output flop.
  } ctl_state_t;

  ctl_state_t s_q;     // Registered state.
  ctl_state_t s_d;     // Next state.
  logic       sclk_w;  // Divider clock level.
  logic       rise_w;  // Divider rising-edge pulse.

  // Status word assembly, used by the status read path.
  function automatic logic [31:0] status_word(input ctl_state_t s);
    logic [31:0] w;
    w = '0;
    w[`ST_DATA_HI:0]           = s.data;
    w[`ST_ALARM]               = s.alarm;
    w[`ST_NEW]                 = s.new_samp;
    w[`ST_SCLK]                = s.sclk;
    w[`ST_MIN_HI:`ST_MIN_LO]   = s.min;
    w[`ST_MAX_HI:`ST_MAX_LO]   = s.max;
    return w;
  endfunction

  // Divider for the sensor clock, steered by the control register.
  sensor_clock_div u_div (
    .clk    (clk),
    .srst   (srst),
    .enable (s_q.ctrl[`CTL_CLK_ON]),
    .ratio  (s_q.ctrl[`CTL_DIV_HI:`CTL_DIV_LO]),
    .sclk   (sclk_w),
    .rise   (rise_w)
  );

  logic apb_wr;    // Write in the access phase.
  logic apb_rd;    // Read in the access phase.
  logic take;      // A reading completes this cycle.
  logic alarm_set; // Alarm condition met this cycle.

  // Next-state logic: bus access, capture, tracking and alarm.
  always_comb
  begin
    s_d       = s_q;
    s_d.irq   = 1'b0;
    s_d.ready = 1'b0;
    s_d.sclk  = sclk_w;
    apb_wr    = psel && penable && pwrite && !s_q.ready;
    apb_rd    = psel && penable && !pwrite && !s_q.ready;
    take      = 1'b0;
    alarm_set = 1'b0;

    // Conversion pacing: one result per twelve sensor clock rises,
    // only while reset and power-down are both released.
    case (s_q.cap)
      CAP_IDLE:
      begin
        s_d.edges = '0;
        if (s_q.ctrl[`CTL_RST_REL] && s_q.ctrl[`CTL_PWR_ON])
          s_d.cap = CAP_RUN;
      end
      CAP_RUN:
      begin
        if (!s_q.ctrl[`CTL_RST_REL] || !s_q.ctrl[`CTL_PWR_ON])
          s_d.cap = CAP_IDLE;
        else if (rise_w)
        begin
          if (s_q.edges == `SCLK_PER_SAMPLE - 4'h1)
          begin
            s_d.edges = '0;
            take      = 1'b1;
          end
          else
            s_d.edges = s_q.edges + 4'h1;
        end
      end
      default: s_d.cap = CAP_IDLE;
    endcase

    // APB access: one wait state, reply on the second access cycle.
    if (psel && penable && !s_q.ready)
    begin
      s_d.ready = 1'b1;
      case (paddr)
        `OFF_CONTROL: s_d.rdata = s_q.ctrl;
        `OFF_STATUS:  s_d.rdata = status_word(s_q);
        `OFF_LIMIT:   s_d.rdata = {25'h0, s_q.limit};
        default:      s_d.rdata = 32'h0000_0000;  // Reserved reads zero.
      endcase
    end

    // Software side of the registers; hardware sets below win.
    if (apb_wr)
    begin
      case (paddr)
        `OFF_CONTROL:
        begin
          s_d.ctrl = '0;  // Reserved bits stay zero.
          s_d.ctrl[`CTL_DIV_HI:`CTL_DIV_LO] =
            pwdata[`CTL_DIV_HI:`CTL_DIV_LO];
          s_d.ctrl[`CTL_ARM:0] = pwdata[`CTL_ARM:0];
        end
        `OFF_STATUS:
        begin
          if (pwdata[`ST_ALARM])
            s_d.alarm = 1'b0;  // Write one clears.
          if (pwdata[`ST_WEN])
          begin
            s_d.min = pwdata[`ST_MIN_HI:`ST_MIN_LO];
            s_d.max = pwdata[`ST_MAX_HI:`ST_MAX_LO];
          end
        end
        `OFF_LIMIT: s_d.limit = pwdata[`ST_DATA_HI:0];
        default: ;  // Reserved writes ignored.
      endcase
    end
    if (apb_rd && paddr == `OFF_STATUS)
      s_d.new_samp = 1'b0;  // Read clears the flag.

    // Capture a reading: data, flag, min/max, alarm.
    if (take)
    begin
      s_d.data     = sensor_data;  // Unsigned Celsius.
      s_d.new_samp = 1'b1;         // Set beats a same-cycle clear.
      if (sensor_data < s_d.min)
        s_d.min = sensor_data;
      if (sensor_data > s_d.max)
        s_d.max = sensor_data;
      alarm_set = s_q.ctrl[`CTL_ARM] && (sensor_data >= s_q.limit);
      if (alarm_set)
      begin
        s_d.alarm = 1'b1;          // Set beats a same-cycle clear.
        s_d.irq   = !s_q.alarm;    // Pulse only on a rise.
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q       <= '0;
      s_q.ctrl  <= `RST_CONTROL;
      s_q.min   <= `RST_MIN;
      s_q.max   <= `RST_MAX;
      s_q.data  <= `RST_DATA;
      s_q.limit <= `RST_LIMIT;
      s_q.cap   <= CAP_IDLE;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops; sensor pins follow control bits.
  assign prdata             = s_q.rdata;
  assign pready             = s_q.ready;
  assign sensor_clk         = s_q.sclk;
  assign sensor_reset_input = s_q.ctrl[`CTL_RST_REL];
  assign sensor_power_on    = s_q.ctrl[`CTL_PWR_ON];
  assign offset_trim        = s_q.ctrl[`CTL_TRIM_HI:`CTL_TRIM_LO];
  assign alarm_irq          = s_q.irq;

  // A completed reading shows in the status data next cycle, together
  // with the new-sample flag.
  sequence took_s;
    take ##1 s_q.new_samp;
  endsequence
  sample_load_a: assert property (@(posedge clk) disable iff (srst)
    took_s |-> s_q.data == $past(sensor_data))
    else $error("reading not loaded into status");
  new_flag_a: assert property (@(posedge clk) disable iff (srst)
    take |=> s_q.new_samp)
    else $error("new sample flag not set");
  minmax_a: assert property (@(posedge clk) disable iff (srst)
    take && !(apb_wr && paddr == `OFF_STATUS)
    |=> s_q.min <= s_q.data && s_q.max >= s_q.data)
    else $error("min or max not tracking reading");
  alarm_cmp_a: assert property (@(posedge clk) disable iff (srst)
    take && s_q.ctrl[`CTL_ARM] && sensor_data >= s_q.limit |=> s_q.alarm)
    else $error("alarm flag missed");
  irq_rise_a: assert property (@(posedge clk) disable iff (srst)
    alarm_irq |-> s_q.alarm && !$past(s_q.alarm))
    else $error("interrupt without alarm rise");
  reserved_rd_a: assert property (@(posedge clk) disable iff (srst)
    apb_rd && paddr > `OFF_LIMIT |=> pready && prdata == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  reset_pin_a: assert property (@(posedge clk) disable iff (srst)
    apb_wr && paddr == `OFF_CONTROL
    |=> sensor_reset_input == $past(pwdata[`CTL_RST_REL])
        && sensor_power_on == $past(pwdata[`CTL_PWR_ON]))
    else $error("sensor pin not following control");
  no_sample_a: assert property (@(posedge clk) disable iff (srst)
    !s_q.ctrl[`CTL_CLK_ON] [*2] |-> !rise_w)
    else $error("sensor clock edge while gated");
endmodule // temp_sensor_controller

// >>> logic/temp_sensor_params.svh
// Constants for the temperature sensor controller: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and design files.
`ifndef TEMP_SENSOR_PARAMS_SVH
`define TEMP_SENSOR_PARAMS_SVH

// Register offsets within the 256-byte APB window.
`define OFF_CONTROL       8'h00
`define OFF_STATUS        8'h04
`define OFF_LIMIT         8'h08
// Control field positions.
`define CTL_CLK_ON        0
`define CTL_RST_REL       1
`define CTL_TRIM_LO       2
`define CTL_TRIM_HI       6
`define CTL_PWR_ON        7
`define CTL_ARM           8
`define CTL_DIV_LO        16
`define CTL_DIV_HI        25
// Status field positions.
`define ST_DATA_HI        6
`define ST_ALARM          8
`define ST_NEW            9
`define ST_WEN            10
`define ST_SCLK           15
`define ST_MIN_LO         16
`define ST_MIN_HI         22
`define ST_MAX_LO         24
`define ST_MAX_HI         30
// Reset values.
`define RST_CONTROL       32'h0000_0000
`define RST_MIN           7'h7F
`define RST_MAX           7'h00
`define RST_DATA          7'h00
`define RST_LIMIT         7'h00
// Sensor clock edges per conversion result.
`define SCLK_PER_SAMPLE   4'hC
`define DIV_ZERO          10'h000
`define DIV_ONE           10'h001

`endif

// >>> logic/temp_sensor_pkg.sv
// Types shared by the temperature sensor controller files.
// Assumes the params header is on the include path.
`include "temp_sensor_params.svh"
package temp_sensor_pkg;
  typedef logic [6:0] temp_t;   // Unsigned Celsius reading, 0 to 127.
  typedef logic [9:0] ratio_t;  // Clock ratio field.
  // Reading capture sequencer states.
  typedef enum logic [1:0]
  {
    CAP_IDLE = 2'b00,
    CAP_RUN  = 2'b01
  } cap_state_t;
endpackage

// >>> logic/sensor_clock_div.sv
// Sensor clock divider: toggles the sensor clock every ratio cycles.
// Assumes one system clock with synchronous active-high reset.
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module sensor_clock_div
  import temp_sensor_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   enable,   // Clock generation on.
  input  wire ratio_t ratio,    // Half period in system cycles.
  output logic        sclk,     // Sensor clock level.
  output logic        rise      // One-cycle pulse with each rising edge.
);
  // Whole state of the divider.
  typedef struct packed {
    ratio_t cnt;
    logic   sclk;
    logic   rise;
  } div_state_t;

  div_state_t s_q;  // Registered state.
  div_state_t s_d;  // Next state.

  // Count up through the half period; a ratio of zero is treated as stopped
  // because a zero divisor has no meaningful frequency.
  always_comb
  begin
    s_d      = s_q;
    s_d.rise = 1'b0;
    if (!enable || ratio == `DIV_ZERO)
    begin
      s_d.cnt  = `DIV_ZERO;   // No sensor clock produced.
      s_d.sclk = 1'b0;
    end
    else if (s_q.cnt + `DIV_ONE >= ratio)
    begin
      s_d.cnt  = `DIV_ZERO;   // Half period done: toggle.
      s_d.sclk = ~s_q.sclk;
      s_d.rise = ~s_q.sclk;
    end
    else
    begin
      s_d.cnt = s_q.cnt + `DIV_ONE;
    end
  end

  // Register the state.
  always_ff @(posedge clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sclk = s_q.sclk;
  assign rise = s_q.rise;

  // Disabled divider keeps the clock low.
  clk_gate_a: assert property (@(posedge clk) disable iff (srst)
    !enable |=> !sclk)
    else $error("sensor clock ran while disabled");
endmodule // sensor_clock_div

// >>> tb/sensor_model.sv
// Model of the analog sensor macro seen by the controller's pins.
// Assumes the controller samples the result bus on sensor clock rises.
`timescale 1ns/1ps
module sensor_model
  import temp_sensor_pkg::*;
(
  input  wire logic  sensor_clk,         // Clock from the controller.
  input  wire logic  sensor_reset_input, // Low holds the sensor in reset.
  input  wire logic  sensor_power_on,    // Low powers the sensor down.
  input  wire temp_t next_temp,          // Temperature the bench shows.
  output temp_t      sensor_data         // Result bus to the controller.
);
  initial sensor_data = 7'h00;
  // Results move on falling edges, so they are settled at each rise.
  always @(negedge sensor_clk)
  begin
    if (sensor_reset_input && sensor_power_on)
      sensor_data <= next_temp;
    else
      sensor_data <= ~sensor_data; // A stopped sensor gives no stable value.
  end
endmodule // sensor_model

// >>> tb/temp_sensor_controller_tb.sv
// Self-checking bench for the temperature sensor controller.
// Assumes the sensor model file and the design package are compiled first.
`timescale 1ns/1ps
module temp_sensor_controller_tb;
  import temp_sensor_pkg::*;
  logic        clk = 1'b0;  // System clock, 4 ns period.
  logic        srst;        // Synchronous reset.
  logic        psel;        // APB select.
  logic        penable;     // APB enable.
  logic        pwrite;      // APB direction.
  logic [7:0]  paddr;       // APB offset.
  logic [31:0] pwdata;      // APB write data.
  logic [31:0] prdata;      // APB read data.
  logic        pready;      // APB ready.
  temp_t       sensor_data; // Result bus.
  temp_t       next_temp;   // Reading the model will show.
  logic        sensor_clk;
  logic        sensor_reset_input;
  logic        sensor_power_on;
  logic [4:0]  offset_trim;
  logic        alarm_irq;
  int          num_errors = 0;
  int          checked = 0;
  int          irq_count = 0;
  logic [31:0] st;          // Last status word read.

  temp_sensor_controller i_dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .sensor_data(sensor_data),
    .sensor_clk(sensor_clk), .sensor_reset_input(sensor_reset_input),
    .sensor_power_on(sensor_power_on), .offset_trim(offset_trim),
    .alarm_irq(alarm_irq));
  sensor_model i_sensor (.sensor_clk(sensor_clk),
    .sensor_reset_input(sensor_reset_input),
    .sensor_power_on(sensor_power_on), .next_temp(next_temp),
    .sensor_data(sensor_data));

  always #2 clk = ~clk;
  // Interrupt pulses last one cycle, so mid-cycle sampling sees each once.
  always @(negedge clk)
    if (alarm_irq === 1'b1)
      irq_count++;

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; an idle cycle follows so no signal is set twice.
  // Ready and read data are looked at 1 ns after an edge, where they have
  // settled; the request stands until the edge that samples ready high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = wd;
    @(posedge clk);
    #1 penable = 1'b1;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
    begin
      check_word(32'h0000_0000, 32'h0000_0001);
      report_and_stop();
    end
    rd = prdata;  // Stands for the whole ready cycle.
    @(posedge clk);
    #1 psel = 1'b0;
    penable = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  // Polls status until a fresh reading is flagged; a hang ends the run.
  task automatic wait_sample();
    for (int n = 0; n < 100; n++)
    begin
      apb(1'b0, 8'h04, 32'h0000_0000, st);
      if (st[9] === 1'b1)
        return;
    end
    check_word(st, 32'h0000_0200);
    report_and_stop();
  endtask

  task automatic test_reset();
    logic [31:0] r;
    apb(1'b0, 8'h00, 32'h0000_0000, r);
    check_word(r, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000, r);
    check_word(r, 32'h007F_0000);
    apb(1'b0, 8'h08, 32'h0000_0000, r);
    check_word(r, 32'h0000_0000);
    check_word({sensor_clk, sensor_power_on, sensor_reset_input}, 0);
    $display("test reset done");
  endtask

  task automatic test_reserved();
    logic [31:0] r;
    wr(8'h0C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h0C, 32'h0000_0000, r);
    check_word(r, 32'h0000_0000);
    apb(1'b0, 8'hFC, 32'h0000_0000, r);
    check_word(r, 32'h0000_0000);
    $display("test reserved done");
  endtask

  // The recommended ratio is only stored and read back: running at it would
  // cost thousands of cycles per reading, so the scenarios use ratio 2.
  task automatic test_startup();
    logic [31:0] r;
    wr(8'h00, 32'h0271_0000);
    apb(1'b0, 8'h00, 32'h0000_0000, r);
    check_word(r, 32'h0271_0000);
    wr(8'h00, 32'h0002_000D);
    check_word(offset_trim, 5'h03);
    check_word({sensor_power_on, sensor_reset_input}, 2'b00);
    wr(8'h00, 32'h0002_000F);
    check_word({sensor_power_on, sensor_reset_input}, 2'b01);
    wr(8'h00, 32'h0002_008F);
    check_word({sensor_power_on, sensor_reset_input}, 2'b11);
    // The model has no analog core, so only the sensor clock wait is kept.
    repeat (100) @(posedge clk);              // 25 sensor clocks.
    #1;
    apb(1'b0, 8'h00, 32'h0000_0000, r);
    check_word(r, 32'h0002_008F);
    $display("test startup done");
  endtask

  // The pin is sampled 1 ns after each edge, where it has settled; the
  // count starts at a rise so the phase at entry does not matter.
  task automatic test_clock();
    int hi;
    int per;
    int n;
    hi = 0;
    per = 0;
    n = 0;
    while (sensor_clk !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sensor_clk !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sensor_clk === 1'b1 && hi < 20)
    begin
      hi++;
      @(posedge clk);
      #1;
    end
    per = hi;
    while (sensor_clk === 1'b0 && per < 40)
    begin
      per++;
      @(posedge clk);
      #1;
    end
    check_word(hi, 2);
    check_word(per, 4);
    $display("test clock done");
  endtask

  // Status bit 15 follows the free-running sensor clock, so it is masked
  // here and checked once the clock is gated.
  task automatic test_alarm();
    logic [31:0] r;
    wr(8'h08, 32'h0000_0032);
    apb(1'b0, 8'h08, 32'h0000_0000, r);
    check_word(r, 32'h0000_0032);
    wr(8'h00, 32'h0002_018F);
    wait_sample();
    wait_sample();
    check_word(st & 32'h7FFF_7FFF, 32'h2828_0228);
    apb(1'b0, 8'h04, 32'h0000_0000, st);
    check_word(st[9], 1'b0);
    next_temp = 7'h32;
    wait_sample();
    wait_sample();
    check_word(st & 32'h7FFF_7FFF, 32'h3228_0332);
    check_word(irq_count, 1);
    next_temp = 7'h3C;
    wait_sample();
    wait_sample();
    check_word(irq_count, 1);
    wr(8'h04, 32'h0000_0100);
    wait_sample();
    check_word(st & 32'h7FFF_7FFF, 32'h3C28_033C);
    check_word(irq_count, 2);
    $display("test alarm done");
  endtask

  // With the clock gated no reading may arrive, so the status fields are
  // steady and the min/max load and the power-first ordering can be tried.
  task automatic test_gate();
    logic        seen;
    logic [31:0] r;
    seen = 1'b0;
    wr(8'h00, 32'h0002_018E);
    repeat (4) @(posedge clk);
    repeat (60)
    begin
      @(posedge clk);
      seen = seen | (sensor_clk !== 1'b0);
    end
    #1;
    check_word(seen, 1'b0);
    apb(1'b0, 8'h04, 32'h0000_0000, r);
    check_word(r, 32'h3C28_013C);
    wr(8'h04, 32'h7010_0500);
    apb(1'b0, 8'h04, 32'h0000_0000, r);
    check_word(r, 32'h7010_003C);
    wr(8'h00, 32'h0000_0080);
    check_word({sensor_power_on, sensor_reset_input}, 2'b10);
    wr(8'h00, 32'h0000_0082);
    check_word({sensor_power_on, sensor_reset_input}, 2'b11);
    $display("test gate done");
  endtask

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    next_temp = 7'h28;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    test_reset();
    test_reserved();
    test_startup();
    test_clock();
    test_alarm();
    test_gate();
    report_and_stop();
  end
endmodule // temp_sensor_controller_tb
